/* include/aadw_pkg.sv */
// Purpose: constants for the audio activity detect and wake block
// Assumes: 50 MHz core clock, byte-wide registers on a plain port
// Notes:   register offsets are page*128 + register number
package aadw_pkg;
  localparam int          ADDR_W          = 8;
  localparam int          DATA_W          = 8;
  localparam int          SAMP_W          = 16;
  // register offsets
  localparam logic [7:0]  OFS_DETECT_EN   = 8'h78;  // page 0, reg 120
  localparam logic [7:0]  OFS_ALERT_CFG   = 8'h9E;  // page 1, reg 30
  localparam logic [7:0]  OFS_STATUS      = 8'hA0;  // page 1, reg 32
  localparam logic [7:0]  OFS_VOICE_THR   = 8'hA1;
  localparam logic [7:0]  OFS_ULTRA_THR   = 8'hA2;
  localparam logic [7:0]  OFS_SOURCE_CFG  = 8'hA3;
  // field positions
  localparam int          VOICE_EN_BIT    = 2;
  localparam int          ULTRA_EN_BIT    = 3;
  localparam int          CHSEL_LSB       = 4;
  localparam int          MODE_LSB        = 6;
  // reset values
  localparam logic [7:0]  RST_DETECT_EN   = 8'h00;
  localparam logic [7:0]  RST_ALERT_CFG   = 8'h00;
  localparam logic [7:0]  RST_VOICE_THR   = 8'h20;
  localparam logic [7:0]  RST_ULTRA_THR   = 8'h10;
  localparam logic [7:0]  RST_SOURCE_CFG  = 8'h01;
  // detector timing
  localparam int          HOLD_SAMPLES    = 4;
  localparam logic [2:0]  HOLD_CNT        = 3'h4;
  localparam int          ENV_SHIFT       = 4;
  // alert modes
  typedef enum logic [1:0] {
    AADW_MODE_NONE = 2'b00,
    AADW_MODE_IRQ  = 2'b01,
    AADW_MODE_WAKE = 2'b10,
    AADW_MODE_RSVD = 2'b11
  } aadw_mode_t;
endpackage

/* hdl/aadw_energy.sv */
// Purpose: envelope energy detector with hold count for one sample stream
// Assumes: samples arrive as one-cycle valid pulses
// Notes:   diff mode tracks sample-to-sample change, a high band proxy
`timescale 1ns/10ps
`default_nettype none
module aadw_energy
  import aadw_pkg::*;
(
  input  wire logic              core_clk_i,
  input  wire logic              rst_n_i,
  input  wire logic              run_i,
  input  wire logic              diff_i,
  input  wire logic [SAMP_W-1:0] samp_i,
  input  wire logic              samp_vld_i,
  input  wire logic [7:0]        thr_i,
  output logic                   hit_o
);
  logic [SAMP_W-1:0] prev;
  logic [SAMP_W-1:0] env;
  logic [SAMP_W-1:0] mag;
  logic [SAMP_W-1:0] diff_v;
  logic [2:0]        hold;

  // magnitude of a signed value
  function automatic logic [SAMP_W-1:0] absv(input logic [SAMP_W-1:0] v);
    absv = v[SAMP_W-1] ? SAMP_W'(~v + 1'b1) : v;
  endfunction

  // pick level or first difference
  always_comb
  begin
    diff_v = SAMP_W'(samp_i - prev);
    mag    = diff_i ? absv(diff_v) : absv(samp_i);
  end

  // leaky envelope, cleared while idle
  always_ff @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      prev <= '0;
      env  <= '0;
    end
    else if (!run_i)
    begin
      prev <= '0;
      env  <= '0;
    end
    else if (samp_vld_i)
    begin
      prev <= samp_i;
      env  <= SAMP_W'(env - (env >> ENV_SHIFT) + (mag >> ENV_SHIFT));
    end
  end

  // hit after the envelope stays over threshold for a few samples
  always_ff @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      hold  <= '0;
      hit_o <= 1'b0;
    end
    else if (!run_i)
    begin
      hold  <= '0;
      hit_o <= 1'b0;
    end
    else if (samp_vld_i)
    begin
      if (env[SAMP_W-2:SAMP_W-9] >= thr_i)
      begin
        hold  <= (hold == HOLD_CNT) ? hold : 3'(hold + 3'h1);
        hit_o <= (hold == HOLD_CNT);
      end
      else
      begin
        hold  <= '0;
        hit_o <= 1'b0;
      end
    end
    else
      hit_o <= 1'b0;
  end
endmodule // aadw_energy
`default_nettype wire

/* hdl/aadw_top.sv */
// Purpose: low power activity detection control for the record path
// Assumes: sample streams synchronous to core_clk_i, valid as pulses
// Notes:   STATUS reads clear the sticky hit flags and the alert level;
//          a hit and a clear in one cycle leave the flag set
//          wake_o stands from the hit until record_done_i is seen,
//          record_start_o pulses once at that hit
//          alert mode 00 and 11 take no action, 01 alerts, 10 wakes
//          SOURCE_CFG bit 0 picks the digital mic path when set
`timescale 1ns/10ps
`default_nettype none
module aadw_top
  import aadw_pkg::*;
(
  input  wire logic              core_clk_i,
  input  wire logic              rst_n_i,
  input  wire logic [ADDR_W-1:0] addr_i,
  input  wire logic [DATA_W-1:0] wdata_i,
  input  wire logic              wr_i,
  input  wire logic              rd_i,
  output logic      [DATA_W-1:0] rdata_o,
  input  wire logic [SAMP_W-1:0] adc_samp_i [4],
  input  wire logic              adc_vld_i,
  input  wire logic [SAMP_W-1:0] pdm_samp_i [4],
  input  wire logic              pdm_vld_i,
  input  wire logic              record_done_i,
  output logic                   alert_o,
  output logic                   wake_o,
  output logic                   record_start_o
);
  logic [DATA_W-1:0] detect_en;
  logic [DATA_W-1:0] alert_cfg;
  logic [DATA_W-1:0] voice_thr;
  logic [DATA_W-1:0] ultra_thr;
  logic [DATA_W-1:0] source_cfg;
  logic              voice_flag;
  logic              ultra_flag;
  logic              voice_run;
  logic              ultra_run;
  logic [1:0]        chsel;
  aadw_mode_t        mode;
  logic [SAMP_W-1:0] sel_samp;
  logic              sel_vld;
  logic              voice_hit;
  logic              ultra_hit;
  logic              any_hit;
  logic              clr_stat;
  logic [DATA_W-1:0] next_rdata;
  logic              watching;
  logic              wake_hit;
  logic              irq_hit;

  typedef enum logic [1:0] {AADW_IDLE, AADW_WATCH, AADW_AWAKE} aadw_state_t;
  aadw_state_t state;

  // strobe qualified by an address match
  function automatic logic bus_hit(input logic              stb,
                                   input logic [ADDR_W-1:0] a,
                                   input logic [ADDR_W-1:0] ofs);
    bus_hit = stb && (a == ofs);
  endfunction

  // at least one detector enabled
  function automatic logic any_enabled(input logic [DATA_W-1:0] en);
    any_enabled = en[VOICE_EN_BIT] || en[ULTRA_EN_BIT];
  endfunction

  // register field decode
  always_comb
  begin
    chsel = alert_cfg[CHSEL_LSB +: 2];
    mode  = aadw_mode_t'(alert_cfg[MODE_LSB +: 2]);
  end

  // enable register: only the two detector enables are kept
  always_ff @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      detect_en <= RST_DETECT_EN;
    else if (bus_hit(wr_i, addr_i, OFS_DETECT_EN))
      detect_en <= wdata_i & 8'h0C;
  end

  // alert mode and channel select, low nibble unused
  always_ff @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      alert_cfg <= RST_ALERT_CFG;
    else if (bus_hit(wr_i, addr_i, OFS_ALERT_CFG))
      alert_cfg <= wdata_i & 8'hF0;
  end

  // voice detector threshold on the envelope
  always_ff @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      voice_thr <= RST_VOICE_THR;
    else if (bus_hit(wr_i, addr_i, OFS_VOICE_THR))
      voice_thr <= wdata_i;
  end

  // ultrasonic detector threshold on the difference envelope
  always_ff @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      ultra_thr <= RST_ULTRA_THR;
    else if (bus_hit(wr_i, addr_i, OFS_ULTRA_THR))
      ultra_thr <= wdata_i;
  end

  // sample source: bit 0 set picks the digital mic path
  always_ff @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      source_cfg <= RST_SOURCE_CFG;
    else if (bus_hit(wr_i, addr_i, OFS_SOURCE_CFG))
      source_cfg <= wdata_i & 8'h01;
  end

  // source mux: analog or digital mic, one channel only
  always_comb
  begin
    if (source_cfg[0])
    begin
      sel_samp = pdm_samp_i[chsel];
      sel_vld  = pdm_vld_i;
    end
    else
    begin
      sel_samp = adc_samp_i[chsel];
      sel_vld  = adc_vld_i;
    end
  end

  // detectors run only while enabled and watching; a hit that lands
  // as the enables drop is ignored so no half-started wake is left
  always_comb
  begin
    watching  = (state == AADW_WATCH) && any_enabled(detect_en);
    voice_run = detect_en[VOICE_EN_BIT] && watching;
    ultra_run = detect_en[ULTRA_EN_BIT] && watching;
    any_hit   = voice_hit || ultra_hit;
    wake_hit  = watching && any_hit && (mode == AADW_MODE_WAKE);
    irq_hit   = watching && any_hit && (mode == AADW_MODE_IRQ);
    clr_stat  = bus_hit(rd_i, addr_i, OFS_STATUS);
  end

  aadw_energy u_voice (
    .core_clk_i (core_clk_i),
    .rst_n_i    (rst_n_i),
    .run_i      (voice_run),
    .diff_i     (1'b0),
    .samp_i     (sel_samp),
    .samp_vld_i (sel_vld),
    .thr_i      (voice_thr),
    .hit_o      (voice_hit)
  );

  aadw_energy u_ultra (
    .core_clk_i (core_clk_i),
    .rst_n_i    (rst_n_i),
    .run_i      (ultra_run),
    .diff_i     (1'b1),
    .samp_i     (sel_samp),
    .samp_vld_i (sel_vld),
    .thr_i      (ultra_thr),
    .hit_o      (ultra_hit)
  );

  // detection state: watch drops to idle when both enables are off; awake holds until record_done_i
  always_ff @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      state <= AADW_IDLE;
    else
    begin
      case (state)
        AADW_IDLE:
        begin
          if (any_enabled(detect_en))
            state <= AADW_WATCH;
        end
        AADW_WATCH:
        begin
          if (!any_enabled(detect_en))
            state <= AADW_IDLE;
          else if (wake_hit)
            state <= AADW_AWAKE;
        end
        AADW_AWAKE:
        begin
          if (record_done_i)
            state <= AADW_IDLE;                       // recording finished
        end
        default:
          state <= AADW_IDLE;
      endcase
    end
  end

  // sticky hit flags, set wins over read clear
  always_ff @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      voice_flag <= 1'b0;
      ultra_flag <= 1'b0;
    end
    else
    begin
      voice_flag <= voice_hit || (voice_flag && !clr_stat);
      ultra_flag <= ultra_hit || (ultra_flag && !clr_stat);
    end
  end

  // interrupt level, set wins over the status read clear
  always_ff @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      alert_o <= 1'b0;
    else if (irq_hit)
      alert_o <= 1'b1;
    else if (clr_stat)
      alert_o <= 1'b0;
  end

  // one-cycle record start at the waking hit
  always_ff @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      record_start_o <= 1'b0;
    else
      record_start_o <= wake_hit;
  end

  // wake level: drops in the same cycle as the awake state ends
  always_ff @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      wake_o <= 1'b0;
    else
      wake_o <= wake_hit ||
                ((state == AADW_AWAKE) && !record_done_i);
  end

  // read mux
  always_comb
  begin
    case (addr_i)
      OFS_DETECT_EN:  next_rdata = detect_en;
      OFS_ALERT_CFG:  next_rdata = alert_cfg;
      OFS_STATUS:     next_rdata = {4'h0, state == AADW_AWAKE,
                                    state == AADW_WATCH,
                                    ultra_flag, voice_flag};
      OFS_VOICE_THR:  next_rdata = voice_thr;
      OFS_ULTRA_THR:  next_rdata = ultra_thr;
      OFS_SOURCE_CFG: next_rdata = source_cfg;
      default:        next_rdata = 8'h00;
    endcase
  end

  // read data one cycle after the strobe, zero otherwise
  always_ff @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      rdata_o <= '0;
    else if (rd_i)
      rdata_o <= next_rdata;
    else
      rdata_o <= '0;
  end
endmodule // aadw_top
`default_nettype wire

/* tb/aadw_props.sv */
// Purpose: port assertions for the activity detect block
// Assumes: one clock, asynchronous active-low reset
// Notes:   enable and mode fields are shadowed from bus writes
`timescale 1ns/10ps
`default_nettype none
module aadw_props
  import aadw_pkg::*;
(
  input wire logic              core_clk_i,
  input wire logic              rst_n_i,
  input wire logic [ADDR_W-1:0] addr_i,
  input wire logic [DATA_W-1:0] wdata_i,
  input wire logic              wr_i,
  input wire logic              rd_i,
  input wire logic [DATA_W-1:0] rdata_o,
  input wire logic              record_done_i,
  input wire logic              alert_o,
  input wire logic              wake_o,
  input wire logic              record_start_o
);
  logic [1:0] en_m;
  logic [1:0] mode_m;
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);
  // shadow of the enables and the alert mode
  always_ff @(posedge core_clk_i or negedge rst_n_i)
    if (!rst_n_i)
    begin
      en_m <= 2'h0;
      mode_m <= 2'h0;
    end
    else if (wr_i)
    begin
      if (addr_i == OFS_DETECT_EN) en_m <= wdata_i[3:2];
      if (addr_i == OFS_ALERT_CFG) mode_m <= wdata_i[7:6];
    end
  // both detectors off for a while
  sequence s_idle_run;
    (en_m == 2'h0)[*8];
  endsequence
  a_rdata_quiet: assert property (
    !rd_i |=> rdata_o == 8'h00) else $error("read data not idle");
  a_start_pulse: assert property (
    record_start_o |=> !record_start_o) else $error("start too long");
  a_start_wake: assert property (
    $rose(wake_o) |-> record_start_o) else $error("wake without start");
  a_wake_hold: assert property (
    wake_o && !record_done_i |=> wake_o) else $error("wake dropped");
  a_wake_ends: assert property (
    wake_o && record_done_i |=> !wake_o) else $error("wake stuck");
  a_alert_hold: assert property (
    alert_o && !(rd_i && addr_i == OFS_STATUS) |=> alert_o)
    else $error("alert dropped");
  a_mode_irq: assert property (
    $rose(alert_o) |-> mode_m == AADW_MODE_IRQ) else $error("bad alert");
  a_mode_wake: assert property (
    $rose(wake_o) |-> mode_m == AADW_MODE_WAKE) else $error("bad wake");
  a_idle_quiet: assert property (
    s_idle_run |=> !$rose(alert_o) && !$rose(wake_o))
    else $error("action while idle");
endmodule // aadw_props
`default_nettype wire

/* tb/aadw_src_model.sv */
// Purpose: microphone sample sources on both record paths
// Assumes: strobes every PERIOD cycles on both paths
// Notes:   lines toggle between strobes so stale data never looks valid
`timescale 1ns/10ps
`default_nettype none
module aadw_src_model
  import aadw_pkg::*;
#(
  parameter int PERIOD = 4
)
(
  input  wire logic              core_clk_i,
  input  wire logic              rst_n_i,
  input  wire logic [1:0]        ch_i,
  input  wire logic [1:0]        shape_i,
  input  wire logic              dig_i,
  input  wire logic [3:0]        noise_i,
  output logic      [SAMP_W-1:0] adc_samp_o [4],
  output logic                   adc_vld_o,
  output logic      [SAMP_W-1:0] pdm_samp_o [4],
  output logic                   pdm_vld_o
);
  int                cnt;
  logic              flip;
  logic [SAMP_W-1:0] loud;
  // steady tone or alternating high band pattern
  assign loud = (shape_i == 2'd1) ? 16'h4000 : (flip ? 16'h2000 : 16'hE000);
  // strobe both paths, loud only on the chosen path and channel
  always @(posedge core_clk_i or negedge rst_n_i)
    if (!rst_n_i)
    begin
      cnt <= 0;
      flip <= 1'b0;
      adc_vld_o <= 1'b0;
      pdm_vld_o <= 1'b0;
      adc_samp_o <= '{default: '0};
      pdm_samp_o <= '{default: '0};
    end
    else
    begin
      cnt <= (cnt == PERIOD - 1) ? 0 : cnt + 1;
      adc_vld_o <= (cnt == 0);
      pdm_vld_o <= (cnt == 0);
      if (cnt == 0) flip <= ~flip;
      for (int i = 0; i < 4; i++)
        if (cnt == 0)
        begin
          adc_samp_o[i] <= (!dig_i && ch_i == i && shape_i != 0) ? loud
                           : {12'h000, noise_i};
          pdm_samp_o[i] <= (dig_i && ch_i == i && shape_i != 0) ? loud
                           : {12'h000, noise_i};
        end
        else
        begin
          adc_samp_o[i] <= ~adc_samp_o[i];
          pdm_samp_o[i] <= ~pdm_samp_o[i];
        end
    end
endmodule // aadw_src_model
`default_nettype wire

/* tb/tb_top.sv */
// Purpose: self-checking bench for the activity detect block
// Assumes: 50 MHz clock, bus driven by non-blocking writes at the edge
// Notes:   read results are queued and compared by a monitor process
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  import aadw_pkg::*;
  logic clk, rst_n, wr, rd, rd_d, done, adc_v, pdm_v, alert, wake, start;
  logic [7:0] addr, wdata, rdata;
  logic [SAMP_W-1:0] adc [4];
  logic [SAMP_W-1:0] pdm [4];
  logic [1:0] ch, shape;
  logic dig;
  logic [31:0] seed;
  logic [7:0] exp_q [$];
  int mismatches, n_tests;
  aadw_top i_dut (.core_clk_i(clk), .rst_n_i(rst_n), .addr_i(addr),
    .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata),
    .adc_samp_i(adc), .adc_vld_i(adc_v), .pdm_samp_i(pdm),
    .pdm_vld_i(pdm_v), .record_done_i(done), .alert_o(alert),
    .wake_o(wake), .record_start_o(start));
  aadw_src_model #(.PERIOD(4)) i_src (.core_clk_i(clk), .rst_n_i(rst_n),
    .ch_i(ch), .shape_i(shape), .dig_i(dig), .noise_i(seed[3:0]),
    .adc_samp_o(adc), .adc_vld_o(adc_v), .pdm_samp_o(pdm),
    .pdm_vld_o(pdm_v));
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction
  task automatic check(input logic [7:0] seen, expd);
    n_tests++;
    if (seen !== expd)
    begin
      $display("wrong value t=%0t seen=%h exp=%h", $time, seen, expd);
      mismatches++;
    end
  endtask
  task automatic final_report;
    $display("checks=%0d mismatches=%0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic wr_reg(input logic [7:0] a, d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [7:0] a, e);
    exp_q.push_back(e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
  endtask
  // settle quietly, arm, play the source, then tidy up
  task automatic run(input logic [7:0] en, cfg, input logic src, d,
                     input logic [1:0] c, sh, input logic ew,
                     input logic [7:0] st);
    logic ga, gw, gs;
    ga = 1'b0;
    gw = 1'b0;
    gs = 1'b0;
    shape <= 2'd0;
    ch <= c;
    dig <= d;
    wr_reg(OFS_SOURCE_CFG, {7'h00, src});
    wr_reg(OFS_ALERT_CFG, {2'b00, cfg[5:0]});
    wr_reg(OFS_DETECT_EN, en);
    repeat (400) @(posedge clk);
    wr_reg(OFS_ALERT_CFG, cfg);
    shape <= sh;
    repeat (600)
    begin
      @(posedge clk);
      ga = ga | (alert === 1'b1);
      gw = gw | (wake === 1'b1);
      gs = gs | (start === 1'b1);
    end
    shape <= 2'd0;
    wr_reg(OFS_DETECT_EN, 8'h00);
    check(ga, st != 8'h00);
    check(gw, ew);
    check(gs, ew);
    done <= 1'b1;
    @(posedge clk);
    done <= 1'b0;
    repeat (2) @(posedge clk);
    check(wake, 1'b0);
    if (st != 8'h00)
    begin
      rd_reg(OFS_STATUS, st);
      repeat (3) @(posedge clk);
      check(alert, 1'b0);
    end
    $display("test done en=%h cfg=%h", en, cfg);
  endtask
  // clock
  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // random noise for the quiet channels
  always @(posedge clk) seed <= xs(seed);
  // read data monitor against the queued expectations
  always @(posedge clk)
  begin
    if (rd_d === 1'b1)
      check(rdata, exp_q.pop_front());
    rd_d <= rd;
  end
  // watchdog
  initial
  begin
    repeat (20000) @(posedge clk);
    mismatches++;
    final_report();
  end
  // main sequence
  initial
  begin
    seed = 32'h8aab_7035;
    {rst_n, wr, rd, done, dig, addr, wdata, ch, shape} = '0;
    mismatches = 0;
    n_tests = 0;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    rd_reg(OFS_DETECT_EN, RST_DETECT_EN);
    rd_reg(OFS_ALERT_CFG, RST_ALERT_CFG);
    rd_reg(OFS_VOICE_THR, RST_VOICE_THR);
    rd_reg(OFS_ULTRA_THR, RST_ULTRA_THR);
    rd_reg(OFS_SOURCE_CFG, RST_SOURCE_CFG);
    rd_reg(8'h00, 8'h00);
    wr_reg(OFS_DETECT_EN, 8'hFF);
    rd_reg(OFS_DETECT_EN, 8'h0C);
    run(8'h04, 8'h60, 1, 1, 2'd2, 2'd1, 0, 8'h01);
    run(8'h08, 8'h50, 0, 0, 2'd1, 2'd2, 0, 8'h02);
    run(8'h04, 8'hB0, 1, 1, 2'd3, 2'd1, 1, 8'h00);
    run(8'h04, 8'h00, 1, 1, 2'd0, 2'd1, 0, 8'h00);
    run(8'h04, 8'hC0, 1, 1, 2'd0, 2'd1, 0, 8'h00);
    run(8'h04, 8'h60, 1, 1, 2'd1, 2'd1, 0, 8'h00);
    run(8'h08, 8'h50, 1, 1, 2'd1, 2'd1, 0, 8'h00);
    run(8'h04, 8'h60, 0, 1, 2'd2, 2'd1, 0, 8'h00);
    run(8'h00, 8'h60, 1, 1, 2'd2, 2'd1, 0, 8'h00);
    run(8'h04, 8'h40, 0, 0, 2'd0, 2'd1, 0, 8'h01);
    final_report();
  end
endmodule // tb_top
bind aadw_top aadw_props i_props (.core_clk_i(core_clk_i),
  .rst_n_i(rst_n_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
  .rd_i(rd_i), .rdata_o(rdata_o), .record_done_i(record_done_i),
  .alert_o(alert_o), .wake_o(wake_o), .record_start_o(record_start_o));
`default_nettype wire
